// ==== core_flow.sv ====
// Program sequencer, stack, data-memory map, table read and status flags.
// Assumes a decoder outside presents one operation at a time on the
// command port, an asynchronous program ROM, and an interrupt control
// block outside that supplies enables and uses the acknowledge pulses.
//
// Behaviour
// - Reset loads program counter with zero
// - Enabled external edge branches to 004H
// - Edge select level chooses rising or falling
// - Enabled timer overflow branches to 008H
// - Table address from PC page or 1011
// - Table low byte to memory, rest high
// - Table pointer is read/write at 07H
// - Table read takes two cycles
// - Six-level PC-only hidden stack
// - Call/interrupt push, returns pop PC
// - Reset points stack index at bottom, level 0
// - RAM 60H..FFH, unused below reads 00H
// - 00H/02H access via memory pointers
// - Indirect to indirect: read 00H, no write
// - Accumulator mapped at 05H, moves through it
// - Status layout at 0AH, bits 7:6 zero
// - Carry from add, no-borrow, rotates
// - Half carry from low nibble
// - Zero flag on zero result
// - Overflow when carries into/out differ
// - Status writes keep power-down and timeout
// - Power-down and timeout set/clear sources
// - Low PC byte at 06H, short jump
// - Taken skip adds dummy, PC plus two
// - External interrupt wins over timer
`timescale 1ns/1ns
module core_flow (
  input  wire logic                    clk,              // System clock
  input  wire logic                    rst_b,            // Sync reset, low
  input  wire logic                    op_valid,         // Operation offered
  input  wire core_flow_pkg::op_t      op_kind,          // Operation code
  input  wire logic [7:0]              op_addr,          // Data address
  input  wire logic [11:0]             op_imm,           // Target/immediate
  input  wire logic                    op_to_mem,        // ALU result to mem
  output logic                         op_ready,         // Operation taken
  output logic [11:0]                  prog_addr,        // ROM address
  input  wire logic [14:0]             prog_word,        // ROM data
  input  wire logic                    ext_int_pin,      // External int pin
  input  wire logic                    edge_select_line, // 1 rising, 0 fall
  input  wire logic                    ext_int_en,       // Ext int enabled
  input  wire logic                    tmr_int_en,       // Timer int enabled
  input  wire logic                    tmr_ovf,          // Timer overflow
  input  wire logic                    wdt_timeout,      // Watchdog expiry
  output logic [11:0]                  pc,               // Program counter
  output logic [7:0]                   acc_out,          // Accumulator
  output logic [7:0]                   status_out,       // Status register
  output logic                         stack_full,       // No free level
  output logic                         ext_int_ack,      // Ext vector taken
  output logic                         tmr_int_ack,      // Tmr vector taken
  output logic                         interrupt_return_pulse        // Int return done
);

  // State
  core_flow_pkg::seq_t seq_q;
  logic [11:0] pc_q;
  logic [11:0] stk_q [0:core_flow_pkg::STACK_DEPTH-1];
  logic [2:0]  sp_q;
  logic [7:0]  ram_q [0:core_flow_pkg::RAM_WORDS-1];
  logic [7:0]  acc_q, mp0_q, mp1_q, table_pointer_q, table_high_byte_q;
  logic        c_q, hc_q, z_q, ov_q, pdf_q, to_q;
  logic [11:0] tab_addr_q;
  logic [7:0]  tab_dest_q;
  logic        tab_ok_q;
  logic        pin_s1_q, pin_s2_q, pin_prev_q;
  logic        ext_pend_q, tmr_pend_q;
  logic        ext_ack_q, tmr_ack_q, interrupt_return_q;

  // Combinational
  logic        take_ext, take_tmr, take_int, accept, full, empty;
  logic        ext_edge, push, pop;
  logic [7:0]  eff_addr, rd_val, wr_addr, wr_data;
  logic        ind_bad, wr_en, skip_take, pcl_wr, is_alu, alu_flags;
  logic        is_arith, is_rot;
  logic [7:0]  alu_res, b_in;
  logic        alu_c, alu_hc, alu_ov, cin;
  logic [8:0]  sum9;
  logic [4:0]  low5;
  logic [7:0]  low8;
  logic [7:0]  ram_idx;

  assign full  = (sp_q == 3'(core_flow_pkg::STACK_DEPTH));
  assign empty = (sp_q == core_flow_pkg::SP_RST);

  // Pin crosses in through two flops; edge seen on the second only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= ext_int_pin;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Polarity chosen by the edge-select level
  assign ext_edge = edge_select_line ? (pin_s2_q & ~pin_prev_q)
                                     : (~pin_s2_q & pin_prev_q);

  // Interrupt arbitration; external first, none while the stack is full
  assign take_ext = (seq_q == core_flow_pkg::seq_run) && ext_pend_q &&
                    ext_int_en && !full;
  assign take_tmr = (seq_q == core_flow_pkg::seq_run) && tmr_pend_q &&
                    tmr_int_en && !full && !take_ext;
  assign take_int = take_ext | take_tmr;
  assign op_ready = (seq_q == core_flow_pkg::seq_run) && !take_int;
  assign accept   = op_valid && op_ready;

  // Pending requests; a new event in the ack cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_pend_q <= 1'b0;
      tmr_pend_q <= 1'b0;
    end else begin
      if (take_ext) ext_pend_q <= 1'b0;
      if (ext_edge) ext_pend_q <= 1'b1;
      if (take_tmr) tmr_pend_q <= 1'b0;
      if (tmr_ovf)  tmr_pend_q <= 1'b1;
    end
  end

  // Indirect resolution through the memory pointers
  always_comb begin
    if (op_addr == core_flow_pkg::ADDR_IND0)
      eff_addr = mp0_q;
    else if (op_addr == core_flow_pkg::ADDR_IND1)
      eff_addr = mp1_q;
    else
      eff_addr = op_addr;
  end
  assign ind_bad = (eff_addr == core_flow_pkg::ADDR_IND0) ||
                   (eff_addr == core_flow_pkg::ADDR_IND1);

  // Data memory read map
  always_comb begin
    ram_idx = 8'(eff_addr - core_flow_pkg::RAM_BASE);
    rd_val  = core_flow_pkg::READ_EMPTY;
    if (ind_bad)
      rd_val = core_flow_pkg::READ_EMPTY;
    else if (eff_addr >= core_flow_pkg::RAM_BASE)
      rd_val = ram_q[ram_idx];
    else begin
      case (eff_addr)
        core_flow_pkg::ADDR_MP0:  rd_val = mp0_q;
        core_flow_pkg::ADDR_MP1:  rd_val = mp1_q;
        core_flow_pkg::ADDR_ACC:  rd_val = acc_q;
        core_flow_pkg::ADDR_PCL:  rd_val = pc_q[7:0];
        core_flow_pkg::ADDR_TABLE_POINTER: rd_val = table_pointer_q;
        core_flow_pkg::ADDR_TABLE_HIGH_BYTE: rd_val = table_high_byte_q;
        core_flow_pkg::ADDR_STAT: rd_val = status_out;
        default:                  rd_val = core_flow_pkg::READ_EMPTY;
      endcase
    end
  end

  // ALU: subtraction is add of the complement, so carry means no borrow
  always_comb begin
    is_arith = 1'b0;
    is_rot   = 1'b0;
    is_alu   = 1'b1;
    b_in     = rd_val;
    cin      = 1'b0;
    case (op_kind)
      core_flow_pkg::op_add: is_arith = 1'b1;
      core_flow_pkg::op_adc: begin
        is_arith = 1'b1;
        cin      = c_q;
      end
      core_flow_pkg::op_sub: begin
        is_arith = 1'b1;
        b_in     = ~rd_val;
        cin      = 1'b1;
      end
      core_flow_pkg::op_sbc: begin
        is_arith = 1'b1;
        b_in     = ~rd_val;
        cin      = c_q;
      end
      core_flow_pkg::op_and, core_flow_pkg::op_or,
      core_flow_pkg::op_xor: is_arith = 1'b0;
      core_flow_pkg::op_rlc, core_flow_pkg::op_rrc: is_rot = 1'b1;
      default: is_alu = 1'b0;
    endcase
  end

  assign sum9 = {1'b0, acc_q} + {1'b0, b_in} + {8'd0, cin};
  assign low5 = {1'b0, acc_q[3:0]} + {1'b0, b_in[3:0]} + {4'd0, cin};
  assign low8 = {1'b0, acc_q[6:0]} + {1'b0, b_in[6:0]} + {7'd0, cin};
  assign alu_hc = low5[4];
  assign alu_ov = low8[7] ^ sum9[8];

  always_comb begin
    alu_res = sum9[7:0];
    alu_c   = sum9[8];
    case (op_kind)
      core_flow_pkg::op_and: alu_res = acc_q & rd_val;
      core_flow_pkg::op_or:  alu_res = acc_q | rd_val;
      core_flow_pkg::op_xor: alu_res = acc_q ^ rd_val;
      core_flow_pkg::op_rlc: begin
        alu_res = {rd_val[6:0], c_q};
        alu_c   = rd_val[7];
      end
      core_flow_pkg::op_rrc: begin
        alu_res = {c_q, rd_val[7:1]};
        alu_c   = rd_val[0];
      end
      default: alu_res = sum9[7:0];
    endcase
  end
  assign alu_flags = accept && is_alu;

  // Single write path into the data map
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = eff_addr;
    wr_data = acc_q;
    if (seq_q == core_flow_pkg::seq_table) begin
      wr_en   = tab_ok_q;
      wr_addr = tab_dest_q;
      wr_data = prog_word[7:0];
    end else if (accept && op_kind == core_flow_pkg::op_mov_to_mem) begin
      wr_en   = !ind_bad;
    end else if (alu_flags && op_to_mem) begin
      wr_en   = !ind_bad;
      wr_data = alu_res;
    end
  end
  assign pcl_wr = wr_en && (wr_addr == core_flow_pkg::ADDR_PCL) &&
                  (seq_q == core_flow_pkg::seq_run);

  // General-purpose RAM
  always_ff @(posedge clk) begin
    if (wr_en && wr_addr >= core_flow_pkg::RAM_BASE)
      ram_q[8'(wr_addr - core_flow_pkg::RAM_BASE)] <= wr_data;
  end

  // Pointer registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mp0_q  <= core_flow_pkg::DATA_RST;
      mp1_q  <= core_flow_pkg::DATA_RST;
      table_pointer_q <= core_flow_pkg::DATA_RST;
    end else if (wr_en) begin
      if (wr_addr == core_flow_pkg::ADDR_MP0)  mp0_q  <= wr_data;
      if (wr_addr == core_flow_pkg::ADDR_MP1)  mp1_q  <= wr_data;
      if (wr_addr == core_flow_pkg::ADDR_TABLE_POINTER) table_pointer_q <= wr_data;
    end
  end

  // Accumulator: moves, immediates and ALU results
  always_ff @(posedge clk) begin
    if (!rst_b)
      acc_q <= core_flow_pkg::DATA_RST;
    else if (accept && op_kind == core_flow_pkg::op_mov_to_acc)
      acc_q <= rd_val;
    else if (accept && op_kind == core_flow_pkg::op_mov_imm)
      acc_q <= op_imm[7:0];
    else if (alu_flags && !op_to_mem)
      acc_q <= alu_res;
    else if (wr_en && wr_addr == core_flow_pkg::ADDR_ACC)
      acc_q <= wr_data;
  end

  // Table read: capture address on accept, transfer in the second cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tab_addr_q <= core_flow_pkg::VEC_RESET;
      tab_dest_q <= core_flow_pkg::DATA_RST;
      tab_ok_q   <= 1'b0;
      table_high_byte_q     <= core_flow_pkg::DATA_RST;
    end else begin
      if (accept && op_kind == core_flow_pkg::op_tab_cur)
        tab_addr_q <= {pc_q[11:8], table_pointer_q};
      if (accept && op_kind == core_flow_pkg::op_tab_last)
        tab_addr_q <= {core_flow_pkg::LAST_PAGE, table_pointer_q};
      if (accept) begin
        tab_dest_q <= eff_addr;
        tab_ok_q   <= !ind_bad;
      end
      if (seq_q == core_flow_pkg::seq_table)
        table_high_byte_q <= {1'b0, prog_word[core_flow_pkg::ROM_W-1:8]};
    end
  end
  assign prog_addr = (seq_q == core_flow_pkg::seq_table) ? tab_addr_q : pc_q;

  // Skip decisions
  always_comb begin
    skip_take = 1'b0;
    if (accept && op_kind == core_flow_pkg::op_sz)
      skip_take = (rd_val == core_flow_pkg::READ_EMPTY);
    if (accept && op_kind == core_flow_pkg::op_snz)
      skip_take = (rd_val != core_flow_pkg::READ_EMPTY);
  end

  // Stack control; a push onto a full stack is dropped
  assign push = take_int ||
                (accept && op_kind == core_flow_pkg::op_call);
  assign pop  = accept && !empty &&
                (op_kind == core_flow_pkg::op_ret ||
                 op_kind == core_flow_pkg::op_interrupt_return);

  // Stack storage, unreachable from the data map
  always_ff @(posedge clk) begin
    if (push && !full)
      stk_q[sp_q] <= take_int ? pc_q : 12'(pc_q + 12'd1);
  end

  // Stack index
  always_ff @(posedge clk) begin
    if (!rst_b)
      sp_q <= core_flow_pkg::SP_RST;
    else if (push && !full)
      sp_q <= 3'(sp_q + 3'd1);
    else if (pop)
      sp_q <= 3'(sp_q - 3'd1);
  end

  // Program counter
  always_ff @(posedge clk) begin
    if (!rst_b)
      pc_q <= core_flow_pkg::VEC_RESET;
    else if (take_ext)
      pc_q <= core_flow_pkg::VEC_EXT;
    else if (take_tmr)
      pc_q <= core_flow_pkg::VEC_TMR;
    else if (accept) begin
      if (op_kind == core_flow_pkg::op_jmp ||
          op_kind == core_flow_pkg::op_call)
        pc_q <= op_imm;
      else if (pop)
        pc_q <= stk_q[3'(sp_q - 3'd1)];
      else if (skip_take)
        pc_q <= 12'(pc_q + 12'd2);
      else if (pcl_wr)
        pc_q <= {pc_q[11:8], wr_data};
      else
        pc_q <= 12'(pc_q + 12'd1);
    end
  end

  // Sequencer: transfers cost a dummy cycle, table reads a second cycle
  always_ff @(posedge clk) begin
    if (!rst_b)
      seq_q <= core_flow_pkg::seq_run;
    else begin
      unique case (seq_q)
        core_flow_pkg::seq_run: begin
          if (take_int)
            seq_q <= core_flow_pkg::seq_dummy;
          else if (accept && (op_kind == core_flow_pkg::op_tab_cur ||
                              op_kind == core_flow_pkg::op_tab_last))
            seq_q <= core_flow_pkg::seq_table;
          else if (accept && (op_kind == core_flow_pkg::op_jmp  ||
                              op_kind == core_flow_pkg::op_call ||
                              pop || skip_take || pcl_wr))
            seq_q <= core_flow_pkg::seq_dummy;
        end
        core_flow_pkg::seq_dummy: seq_q <= core_flow_pkg::seq_run;
        core_flow_pkg::seq_table: seq_q <= core_flow_pkg::seq_run;
      endcase
    end
  end

  // Arithmetic flags; a status write touches only the low four bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      c_q  <= 1'b0;
      hc_q <= 1'b0;
      z_q  <= 1'b0;
      ov_q <= 1'b0;
    end else if (alu_flags) begin
      z_q <= (alu_res == core_flow_pkg::READ_EMPTY);
      if (is_arith) begin
        c_q  <= alu_c;
        hc_q <= alu_hc;
        ov_q <= alu_ov;
      end
      if (is_rot) c_q <= alu_c;
    end else if (wr_en && wr_addr == core_flow_pkg::ADDR_STAT) begin
      c_q  <= wr_data[core_flow_pkg::ST_C];
      hc_q <= wr_data[core_flow_pkg::ST_HC];
      z_q  <= wr_data[core_flow_pkg::ST_Z];
      ov_q <= wr_data[core_flow_pkg::ST_OV];
    end
  end

  // Power-down and timeout; a timeout in a clearing cycle still sets
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pdf_q <= 1'b0;
      to_q  <= 1'b0;
    end else begin
      if (accept && op_kind == core_flow_pkg::op_halt) begin
        pdf_q <= 1'b1;
        to_q  <= 1'b0;
      end
      if (accept && op_kind == core_flow_pkg::op_watchdog_clear_instr) begin
        pdf_q <= 1'b0;
        to_q  <= 1'b0;
      end
      if (wdt_timeout) to_q <= 1'b1;
    end
  end

  // Notices for the interrupt control block outside
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_ack_q <= 1'b0;
      tmr_ack_q <= 1'b0;
      interrupt_return_q    <= 1'b0;
    end else begin
      ext_ack_q <= take_ext;
      tmr_ack_q <= take_tmr;
      interrupt_return_q    <= accept && op_kind == core_flow_pkg::op_interrupt_return;
    end
  end

  assign pc          = pc_q;
  assign acc_out     = acc_q;
  assign status_out  = {2'b00, to_q, pdf_q, ov_q, z_q, hc_q, c_q};
  assign stack_full  = full;
  assign ext_int_ack = ext_ack_q;
  assign tmr_int_ack = tmr_ack_q;
  assign interrupt_return_pulse  = interrupt_return_q;

endmodule : core_flow

// ==== core_flow_pkg.sv ====
// Constants and types shared by the program-flow core.
// Assumes a single 25 MHz clock domain and one instruction per clock, two for transfers and table reads.
package core_flow_pkg;

  // Widths and sizes
  localparam int PC_W        = 12;
  localparam int DATA_W      = 8;
  localparam int STACK_DEPTH = 6;
  localparam int SP_W        = 3;
  localparam int ROM_W       = 15;   // Table word bits that reach registers
  localparam int TABLE_HIGH_BYTE_USED   = 7;    // Upper table bits kept in high byte
  localparam int RAM_WORDS   = 160;

  // Program addresses
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT   = 12'h004;
  localparam logic [11:0] VEC_TMR   = 12'h008;
  localparam logic [3:0]  LAST_PAGE = 4'hb;

  // Data memory map
  localparam logic [7:0] ADDR_IND0  = 8'h00;
  localparam logic [7:0] ADDR_MP0   = 8'h01;
  localparam logic [7:0] ADDR_IND1  = 8'h02;
  localparam logic [7:0] ADDR_MP1   = 8'h03;
  localparam logic [7:0] ADDR_ACC   = 8'h05;
  localparam logic [7:0] ADDR_PCL   = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER  = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_BYTE  = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0a;
  localparam logic [7:0] RAM_BASE   = 8'h60;
  localparam logic [7:0] READ_EMPTY = 8'h00;

  // Status bit positions
  localparam int ST_C   = 0;
  localparam int ST_HC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_OV  = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO  = 5;

  // Reset values
  localparam logic [7:0]  DATA_RST = 8'h00;
  localparam logic [2:0]  SP_RST   = 3'h0;

  // Operations presented on the command port
  typedef enum logic [4:0] {
    op_nop, op_jmp, op_call, op_ret, op_interrupt_return,
    op_mov_to_acc, op_mov_to_mem, op_mov_imm,
    op_add, op_adc, op_sub, op_sbc,
    op_and, op_or, op_xor, op_rlc, op_rrc,
    op_sz, op_snz, op_tab_cur, op_tab_last,
    op_halt, op_watchdog_clear_instr
  } op_t;

  // Sequencer states
  typedef enum logic [1:0] {seq_run, seq_dummy, seq_table} seq_t;

endpackage : core_flow_pkg

// ==== core_flow_props.sv ====
// Concurrent checks on the ports of the program-flow core.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module core_flow_props (
  input wire logic               clk,         // System clock
  input wire logic               rst_b,       // Sync reset, low
  input wire logic               op_valid,    // Operation offered
  input wire core_flow_pkg::op_t op_kind,     // Operation code
  input wire logic [7:0]         op_addr,     // Data address
  input wire logic [11:0]        op_imm,      // Target
  input wire logic               op_ready,    // Operation taken
  input wire logic [11:0]        prog_addr,   // ROM address
  input wire logic [11:0]        pc,          // Program counter
  input wire logic [7:0]         acc_out,     // Accumulator
  input wire logic [7:0]         status_out,  // Status register
  input wire logic               stack_full,  // No free level
  input wire logic               ext_int_ack, // External taken
  input wire logic               tmr_int_ack, // Timer taken
  input wire logic               interrupt_return_pulse,  // Return done
  input wire logic               wdt_timeout  // Watchdog expiry
);
  logic [3:0] page_q; // Page of the previous cycle
  logic       take;   // Operation accepted this cycle
  // Page history, since short jumps and table reads keep it
  always_ff @(posedge clk) begin
    page_q <= pc[11:8];
  end
  assign take = op_valid && op_ready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_reset_state: assert property ($rose(rst_b) |-> pc == 12'h000 && !stack_full)
    else $error("state after reset wrong");
  chk_ext_vector: assert property (ext_int_ack |-> pc == 12'h004 && !tmr_int_ack)
    else $error("external vector wrong");
  chk_tmr_vector: assert property (tmr_int_ack |-> pc == 12'h008)
    else $error("timer vector wrong");
  chk_stack_room: assert property ((ext_int_ack || tmr_int_ack) |-> !$past(stack_full))
    else $error("interrupt taken on full stack");
  chk_jump_target: assert property (take && (op_kind == core_flow_pkg::op_jmp ||
    op_kind == core_flow_pkg::op_call) |=> pc == $past(op_imm) && !op_ready)
    else $error("jump target wrong");
  chk_short_jump: assert property (take && op_kind == core_flow_pkg::op_mov_to_mem &&
    op_addr == 8'h06 |=> pc == {page_q, $past(acc_out)})
    else $error("low byte jump wrong");
  chk_table_page: assert property (take && (op_kind == core_flow_pkg::op_tab_cur ||
    op_kind == core_flow_pkg::op_tab_last) |=> !op_ready ##0 prog_addr[11:8] ==
    ($past(op_kind) == core_flow_pkg::op_tab_last ? 4'hb : page_q))
    else $error("table cycle wrong");
  chk_status_zero: assert property (status_out[7:6] == 2'b00)
    else $error("status top bits set");
  chk_status_keep: assert property (take && op_kind == core_flow_pkg::op_mov_to_mem &&
    op_addr == 8'h0a && !wdt_timeout |=> ((status_out ^ $past(status_out)) & 8'h30) == 8'h00)
    else $error("status write touched power flags");
  chk_interrupt_return_pulse: assert property (take && op_kind == core_flow_pkg::op_interrupt_return |=> interrupt_return_pulse)
    else $error("return pulse missing");
  // Main scenarios reached
  cov_ext: cover property (ext_int_ack);
  cov_tmr: cover property (tmr_int_ack);
  cov_full: cover property (stack_full);
endmodule : core_flow_props
bind core_flow core_flow_props core_flow_props_i (.clk(clk), .rst_b(rst_b),
  .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr), .op_imm(op_imm),
  .op_ready(op_ready), .prog_addr(prog_addr), .pc(pc), .acc_out(acc_out),
  .status_out(status_out), .stack_full(stack_full), .ext_int_ack(ext_int_ack),
  .tmr_int_ack(tmr_int_ack), .interrupt_return_pulse(interrupt_return_pulse),
  .wdt_timeout(wdt_timeout));

// ==== core_flow_test.sv ====
// Self-checking bench for the program-flow core.
// Assumes the core alone; the bench plays decoder, ROM and pins.
`timescale 1ns/1ns
module core_flow_test;
  logic        clk, rst_b, op_valid, op_to_mem, op_ready, stack_full;
  logic        ext_int_pin, edge_select_line, ext_int_en, tmr_int_en;
  logic        tmr_ovf, wdt_timeout, ext_int_ack, tmr_int_ack, interrupt_return_pulse;
  logic [7:0]  op_addr, acc_out, status_out;
  logic [11:0] op_imm, prog_addr, pc;
  logic [14:0] prog_word;
  core_flow_pkg::op_t op_kind;
  int          failures, n_tests, cycles;
  core_flow core_flow_i (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
    .op_kind(op_kind), .op_addr(op_addr), .op_imm(op_imm),
    .op_to_mem(op_to_mem), .op_ready(op_ready), .prog_addr(prog_addr),
    .prog_word(prog_word), .ext_int_pin(ext_int_pin),
    .edge_select_line(edge_select_line), .ext_int_en(ext_int_en),
    .tmr_int_en(tmr_int_en), .tmr_ovf(tmr_ovf), .wdt_timeout(wdt_timeout),
    .pc(pc), .acc_out(acc_out), .status_out(status_out),
    .stack_full(stack_full), .ext_int_ack(ext_int_ack),
    .tmr_int_ack(tmr_int_ack), .interrupt_return_pulse(interrupt_return_pulse));
  // 25 MHz clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic cmp(input string s, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  // Offer one operation at a falling edge, hold it until taken
  task automatic op(input core_flow_pkg::op_t k, input logic [7:0] a,
                    input logic [11:0] i);
    int n;
    @(negedge clk);
    op_valid = 1;
    op_kind = k;
    op_addr = a;
    op_imm = i;
    n = 0;
    while (op_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    op_valid = 0;
  endtask : op
  // Data moves always pass through the accumulator
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(core_flow_pkg::op_mov_imm, 8'h00, {4'h0, d});
    op(core_flow_pkg::op_mov_to_mem, a, 12'h000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(core_flow_pkg::op_mov_to_acc, a, 12'h000);
    cmp("read", {4'h0, e}, {4'h0, acc_out});
  endtask : rd
  task automatic alu(input core_flow_pkg::op_t k, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] r,
                     input logic [7:0] s);
    wr(8'h62, b);
    op(core_flow_pkg::op_mov_imm, 8'h00, {4'h0, a});
    op(k, 8'h62, 12'h000);
    cmp("alu", {4'h0, r}, {4'h0, acc_out});
    cmp("flags", {4'h0, s}, {4'h0, status_out});
  endtask : alu
  task automatic wait_ack(input logic tmr, input logic [11:0] v);
    int n;
    n = 0;
    while ((tmr ? tmr_int_ack : ext_int_ack) !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp("vector", v, pc);
  endtask : wait_ack
  initial begin
    {rst_b, op_valid, op_to_mem, ext_int_pin, edge_select_line} = 5'h00;
    {tmr_ovf, wdt_timeout, ext_int_en, tmr_int_en} = 4'h3;
    {op_addr, op_imm, prog_word, failures, n_tests, cycles} = '0;
    op_kind = core_flow_pkg::op_nop;
    repeat (5) @(negedge clk);
    rst_b = 1;
    cmp("pc", 12'h000, pc);
    cmp("full", 12'h000, {11'h0, stack_full});
    wr(8'h60, 8'h5a);
    rd(8'h60, 8'h5a);
    rd(8'h04, 8'h00);
    wr(8'h01, 8'h60);
    rd(8'h00, 8'h5a);
    wr(8'h03, 8'h60);
    wr(8'h02, 8'ha5);
    rd(8'h60, 8'ha5);
    wr(8'h01, 8'h02);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h77);
    rd(8'h02, 8'ha5);
    $display("test memory map done");
    wr(8'h07, 8'h34);
    rd(8'h07, 8'h34);
    op(core_flow_pkg::op_jmp, 8'h00, 12'h5f0);
    op(core_flow_pkg::op_tab_cur, 8'h61, 12'h000);
    cmp("table", 12'h534, prog_addr);
    prog_word = 15'h7abc;
    op(core_flow_pkg::op_tab_last, 8'h62, 12'h000);
    cmp("table", 12'hb34, prog_addr);
    prog_word = 15'h7f21;
    rd(8'h61, 8'hbc);
    rd(8'h62, 8'h21);
    rd(8'h08, 8'h7f);
    $display("test table read done");
    op(core_flow_pkg::op_jmp, 8'h00, 12'h123);
    cmp("pc", 12'h123, pc);
    wr(8'h06, 8'h45);
    cmp("pc", 12'h145, pc);
    op(core_flow_pkg::op_jmp, 8'h00, 12'h300);
    op(core_flow_pkg::op_sz, 8'h04, 12'h000);
    repeat (2) @(negedge clk);
    cmp("pc", 12'h302, pc);
    op(core_flow_pkg::op_jmp, 8'h00, 12'h300);
    op(core_flow_pkg::op_snz, 8'h04, 12'h000);
    cmp("pc", 12'h301, pc);
    $display("test jumps done");
    alu(core_flow_pkg::op_add, 8'hff, 8'h01, 8'h00, 8'h07);
    alu(core_flow_pkg::op_add, 8'h7f, 8'h01, 8'h80, 8'h0a);
    alu(core_flow_pkg::op_sub, 8'h05, 8'h03, 8'h02, 8'h03);
    alu(core_flow_pkg::op_sub, 8'h03, 8'h05, 8'hfe, 8'h00);
    wr(8'h0a, 8'hff);
    cmp("status", 12'h00f, {4'h0, status_out});
    op(core_flow_pkg::op_halt, 8'h00, 12'h000);
    cmp("status", 12'h01f, {4'h0, status_out});
    wr(8'h0a, 8'h00);
    cmp("status", 12'h010, {4'h0, status_out});
    wdt_timeout = 1;
    @(negedge clk);
    wdt_timeout = 0;
    cmp("status", 12'h030, {4'h0, status_out});
    op(core_flow_pkg::op_watchdog_clear_instr, 8'h00, 12'h000);
    cmp("status", 12'h000, {4'h0, status_out});
    // Result to memory leaves the accumulator alone; rotates use carry
    op_to_mem = 1;
    alu(core_flow_pkg::op_rlc, 8'h11, 8'h81, 8'h11, 8'h01);
    op_to_mem = 0;
    rd(8'h62, 8'h02);
    alu(core_flow_pkg::op_rrc, 8'h00, 8'h01, 8'h80, 8'h01);
    $display("test flags done");
    op(core_flow_pkg::op_jmp, 8'h00, 12'h100);
    for (int i = 0; i < 6; i++) op(core_flow_pkg::op_call, 8'h00, 12'h200 + i);
    cmp("full", 12'h001, {11'h0, stack_full});
    for (int k = 0; k < 6; k++) begin
      op(k == 5 ? core_flow_pkg::op_interrupt_return : core_flow_pkg::op_ret, 8'h00,
         12'h000);
      cmp("pc", k < 5 ? 12'h205 - k : 12'h101, pc);
    end
    cmp("interrupt_return", 12'h001, {11'h0, interrupt_return_pulse});
    $display("test stack done");
    ext_int_pin = 1;
    repeat (8) @(negedge clk);
    cmp("pc", 12'h101, pc);
    ext_int_pin = 0;
    wait_ack(1'b0, 12'h004);
    edge_select_line = 1;
    repeat (4) @(negedge clk);
    ext_int_pin = 1;
    repeat (2) @(negedge clk);
    tmr_ovf = 1;
    @(negedge clk);
    tmr_ovf = 0;
    wait_ack(1'b0, 12'h004);
    wait_ack(1'b1, 12'h008);
    // Full stack holds a timer request back until a level frees
    for (int i = 0; i < 3; i++) op(core_flow_pkg::op_call, 8'h00, 12'h400);
    tmr_ovf = 1;
    @(negedge clk);
    tmr_ovf = 0;
    repeat (4) @(negedge clk);
    cmp("pc", 12'h400, pc);
    op(core_flow_pkg::op_ret, 8'h00, 12'h000);
    wait_ack(1'b1, 12'h008);
    $display("test interrupts done");
    give_verdict();
  end
endmodule : core_flow_test
